// ===== cmd_divider.sv
// Purpose: Iterative restoring divider, one quotient bit per clock
// Assumes: Operands held stable by caller only at start
// Notes: Quotient truncated toward zero for signed operation
`timescale 1ns/1ps
module cmd_divider
    import cmd_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire logic is_signed,
    input wire logic [XLEN-1:0] dividend,
    input wire logic [XLEN-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [XLEN-1:0] quotient
);
    logic [XLEN-1:0] rem_r;
    logic [XLEN-1:0] quo_r;
    logic [XLEN-1:0] dsr_r;
    logic neg_r;
    logic [DIV_CNT_W-1:0] cnt_r;
    logic [XLEN:0] trial;

    function automatic logic [XLEN-1:0] magnitude(input logic [XLEN-1:0] v, input logic sgn);
        magnitude = (sgn && v[XLEN-1]) ? (~v + 1'b1) : v;
    endfunction

    assign trial = {rem_r, quo_r[XLEN-1]} - {1'b0, dsr_r};

    // ------------------------------------------------------------
    // Shift-subtract loop
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rem_r <= '0;
            quo_r <= '0;
            dsr_r <= '0;
            neg_r <= 1'b0;
            cnt_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= '0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                rem_r <= '0;
                quo_r <= magnitude(dividend, is_signed);
                dsr_r <= magnitude(divisor, is_signed);
                neg_r <= is_signed && (dividend[XLEN-1] ^ divisor[XLEN-1]);
                cnt_r <= DIV_CNT_W'(XLEN);
                busy <= 1'b1;
            end
            else if (busy)
            begin
                // Truncating: remainder simply dropped at the end
                if (!trial[XLEN])
                begin
                    rem_r <= trial[XLEN-1:0];
                    quo_r <= {quo_r[XLEN-2:0], 1'b1};
                end
                else
                begin
                    rem_r <= {rem_r[XLEN-2:0], quo_r[XLEN-1]};
                    quo_r <= {quo_r[XLEN-2:0], 1'b0};
                end
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == DIV_CNT_W'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= neg_r ? ~({quo_r[XLEN-2:0], ~trial[XLEN]}) + 1'b1
                                      : {quo_r[XLEN-2:0], ~trial[XLEN]};
                end
            end
        end
    end
endmodule

// ===== cmd_exec.sv
// Purpose: Execution slice for conditional move, context sync, custom slots and divide
// Assumes: Pipeline stalls while busy is high; operands valid with insn_valid
// Notes: One instruction taken per idle cycle
`timescale 1ns/1ps
module cmd_exec
    import cmd_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    input wire logic [XLEN-1:0] opnd_a,
    input wire logic [XLEN-1:0] opnd_b,
    input wire logic cond_flag,
    input wire logic overflow_exception_enable,
    input wire logic div_zero_exception_enable,
    input wire logic pipeline_idle,
    output logic busy,
    output logic wb_valid,
    output logic [4:0] wb_dest,
    output logic [XLEN-1:0] wb_data,
    output logic overflow_flag_we,
    output logic overflow_flag,
    output logic carry_flag_we,
    output logic carry_flag,
    output logic range_exception,
    output logic illegal_insn,
    output logic pipeline_flush,
    output logic context_reload
);
    cmd_state_t state_r;
    logic [4:0] dest_r;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [XLEN-1:0] div_quo;
    logic [DIV_CNT_W-1:0] drain_r;
    logic take;
    logic is_cmov;
    logic is_div;
    logic is_divu;
    logic is_sync;
    logic is_cust;
    logic zero_div;

    function automatic logic alu_match(input logic [INSN_W-1:0] w, input logic [1:0] sub, input logic [3:0] fn);
        alu_match = (w[OPC_HI:OPC_LO] == OPC_ALU) && (w[SUB_HI:SUB_LO] == sub) && (w[FN_HI:FN_LO] == fn);
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign take = insn_valid && (state_r == CMD_IDLE);
    assign is_cmov = alu_match(insn, SUB_CMOV, FN_CMOV);
    assign is_div = alu_match(insn, SUB_DIV, FN_DIV);
    assign is_divu = alu_match(insn, SUB_DIV, FN_DIVU);
    assign is_sync = (insn == INSN_CSYNC);
    // No custom instruction is built in, so every slot traps
    assign is_cust = ((insn[OPC_HI:OPC_LO] >= OPC_CUST1) && (insn[OPC_HI:OPC_LO] <= OPC_CUST4))
                  || ((insn[OPC_HI:OPC_LO] >= OPC_CUST5) && (insn[OPC_HI:OPC_LO] <= OPC_CUST8));
    assign zero_div = (opnd_b == '0);
    assign div_start = take && (is_div || is_divu) && !zero_div;

    cmd_divider u_div
    (
        .mclk(mclk),
        .resetn(resetn),
        .start(div_start),
        .is_signed(is_div),
        .dividend(opnd_a),
        .divisor(opnd_b),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_quo)
    );

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= CMD_IDLE;
            drain_r <= '0;
            busy <= 1'b0;
        end
        else
        begin
            case (state_r)
                CMD_IDLE:
                begin
                    if (div_start)
                    begin
                        state_r <= CMD_DIV;
                        busy <= 1'b1;
                    end
                    else if (take && is_sync)
                    begin
                        state_r <= CMD_SYNC;
                        drain_r <= DIV_CNT_W'(CSYNC_DRAIN_CYCLES);
                        busy <= 1'b1;
                    end
                end
                CMD_DIV:
                begin
                    if (div_done)
                    begin
                        state_r <= CMD_IDLE;
                        busy <= 1'b0;
                    end
                end
                CMD_SYNC:
                begin
                    // Hold until the rest of the core has drained
                    if (drain_r != '0)
                        drain_r <= drain_r - 1'b1;
                    else if (pipeline_idle && !div_busy)
                    begin
                        state_r <= CMD_IDLE;
                        busy <= 1'b0;
                    end
                end
                default:
                begin
                    state_r <= CMD_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Writeback and flags
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            dest_r <= '0;
            wb_valid <= 1'b0;
            wb_dest <= '0;
            wb_data <= '0;
            overflow_flag_we <= 1'b0;
            overflow_flag <= 1'b0;
            carry_flag_we <= 1'b0;
            carry_flag <= 1'b0;
            range_exception <= 1'b0;
            illegal_insn <= 1'b0;
        end
        else
        begin
            wb_valid <= 1'b0;
            overflow_flag_we <= 1'b0;
            carry_flag_we <= 1'b0;
            range_exception <= 1'b0;
            illegal_insn <= 1'b0;
            if (take)
                dest_r <= insn[RD_HI:RD_LO];
            if (take && is_cmov)
            begin
                wb_valid <= 1'b1;
                wb_dest <= insn[RD_HI:RD_LO];
                wb_data <= cond_flag ? opnd_a : opnd_b;
            end
            if (take && is_div)
            begin
                overflow_flag_we <= 1'b1;
                overflow_flag <= zero_div;
            end
            if (take && is_divu)
            begin
                carry_flag_we <= 1'b1;
                carry_flag <= zero_div;
            end
            if (take && (is_div || is_divu) && zero_div)
                range_exception <= overflow_exception_enable && div_zero_exception_enable;
            if (take && is_cust)
                illegal_insn <= 1'b1;
            if (div_done)
            begin
                wb_valid <= 1'b1;
                wb_dest <= dest_r;
                wb_data <= div_quo;
            end
        end
    end

    // ------------------------------------------------------------
    // Context synchronization outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pipeline_flush <= 1'b0;
            context_reload <= 1'b0;
        end
        else
        begin
            pipeline_flush <= (state_r == CMD_SYNC) && (drain_r == '0) && pipeline_idle && !div_busy;
            context_reload <= (state_r == CMD_SYNC) && (drain_r == '0) && pipeline_idle && !div_busy;
        end
    end
endmodule

// ===== cmd_exec_asserts.sv
// Purpose: Concurrent checks on the ports of cmd_exec
// Assumes: One clock mclk, asynchronous active-low resetn
// Notes: Bound into every cmd_exec instance
`timescale 1ns/1ps
module cmd_exec_chk
    import cmd_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    input wire logic [XLEN-1:0] opnd_a,
    input wire logic [XLEN-1:0] opnd_b,
    input wire logic cond_flag,
    input wire logic overflow_exception_enable,
    input wire logic div_zero_exception_enable,
    input wire logic pipeline_idle,
    input wire logic busy,
    input wire logic wb_valid,
    input wire logic [4:0] wb_dest,
    input wire logic [XLEN-1:0] wb_data,
    input wire logic overflow_flag_we,
    input wire logic overflow_flag,
    input wire logic carry_flag_we,
    input wire logic carry_flag,
    input wire logic range_exception,
    input wire logic illegal_insn,
    input wire logic pipeline_flush,
    input wire logic context_reload
);
    logic tk, alu, bz, en, cmv, sdv, udv;
    logic [4:0] rd;
    logic [XLEN-1:0] sel;
    assign tk = insn_valid && !busy;
    assign alu = tk && insn[OPC_HI:OPC_LO] == OPC_ALU;
    assign cmv = alu && insn[SUB_HI:SUB_LO] == SUB_CMOV && insn[FN_HI:FN_LO] == FN_CMOV;
    assign sdv = alu && insn[SUB_HI:SUB_LO] == SUB_DIV && insn[FN_HI:FN_LO] == FN_DIV;
    assign udv = alu && insn[SUB_HI:SUB_LO] == SUB_DIV && insn[FN_HI:FN_LO] == FN_DIVU;
    assign bz = opnd_b == '0;
    assign en = overflow_exception_enable && div_zero_exception_enable;
    assign rd = insn[RD_HI:RD_LO];
    assign sel = cond_flag ? opnd_a : opnd_b;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_cmov_result: assert property (cmv |=> wb_valid && wb_data == $past(sel) && wb_dest == $past(rd))
        else $error("cmov result wrong");
    chk_sdiv_flag: assert property (sdv |=> overflow_flag_we && overflow_flag == $past(bz) && !carry_flag_we)
        else $error("signed divide flag wrong");
    chk_udiv_flag: assert property (udv |=> carry_flag_we && carry_flag == $past(bz) && !overflow_flag_we)
        else $error("unsigned divide flag wrong");
    chk_range_exc: assert property ((sdv || udv) && bz |=> range_exception == $past(en))
        else $error("range exception wrong");
    chk_div_answer: assert property ((sdv || udv) && !bz |=> busy ##33 (wb_valid && !busy))
        else $error("divide answer late");
    chk_zdiv_nowb: assert property ((sdv || udv) && bz |=> !busy && !wb_valid)
        else $error("zero divide wrote back");
    chk_custom_trap: assert property (tk && insn[30:28] == 3'h7 |=> illegal_insn && !wb_valid)
        else $error("custom opcode not trapped");
    chk_sync_flush: assert property (tk && insn == INSN_CSYNC |=> busy ##[3:300] pipeline_flush)
        else $error("sync never flushed");
    chk_flush_pair: assert property (pipeline_flush |-> context_reload && !busy && $past(pipeline_idle))
        else $error("flush without reload or idle");
    cover property (cmv && cond_flag);
    cover property (range_exception);
    cover property (pipeline_flush);
endmodule
bind cmd_exec cmd_exec_chk u_chk (.*);

// ===== cmd_pipe_model.sv
// Purpose: Rest of the core seen from cmd_exec
// Assumes: Outstanding work begins when busy rises
// Notes: hold_cycles sets how long that work keeps the core busy
`timescale 1ns/1ps
module cmd_pipe_model
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic busy,
    input wire logic [3:0] hold_cycles,
    output logic pipeline_idle
);
    logic [3:0] work_r;
    logic busy_r;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            work_r <= 4'h0;
            busy_r <= 1'b0;
        end
        else
        begin
            busy_r <= busy;
            if (busy && !busy_r)
                work_r <= hold_cycles;
            else if (work_r != 4'h0)
                work_r <= work_r - 4'h1;
        end
    end
    assign pipeline_idle = work_r == 4'h0;
endmodule

// ===== cmd_pkg.sv
// Purpose: Constants for the conditional move / divide execution slice
// Assumes: 32-bit instruction words, 32-bit data path by default
// Notes: Opcode fields and encodings shared by decoder and checker
package cmd_pkg;
    localparam int XLEN = 32;
    localparam int INSN_W = 32;
    localparam int DIV_CNT_W = 7;
    localparam int CSYNC_DRAIN_CYCLES = 2;
    localparam logic [5:0] OPC_ALU = 6'h38;
    localparam logic [3:0] FN_CMOV = 4'he;
    localparam logic [3:0] FN_DIV = 4'h9;
    localparam logic [3:0] FN_DIVU = 4'ha;
    localparam logic [1:0] SUB_CMOV = 2'h0;
    localparam logic [1:0] SUB_DIV = 2'h3;
    localparam logic [31:0] INSN_CSYNC = 32'h23000000;
    localparam logic [5:0] OPC_CUST1 = 6'h1c;
    localparam logic [5:0] OPC_CUST4 = 6'h1f;
    localparam logic [5:0] OPC_CUST5 = 6'h3c;
    localparam logic [5:0] OPC_CUST8 = 6'h3f;
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int RD_HI = 25;
    localparam int RD_LO = 21;
    localparam int SUB_HI = 9;
    localparam int SUB_LO = 8;
    localparam int FN_HI = 3;
    localparam int FN_LO = 0;
    typedef enum logic [1:0]
    {
        CMD_IDLE = 2'b00,
        CMD_DIV = 2'b01,
        CMD_SYNC = 2'b10
    } cmd_state_t;
endpackage

// ===== cond_move_divide_unit_tb_top.sv
// Purpose: Self-checking bench for cmd_exec
// Assumes: Default package widths
// Notes: Each scenario drives and judges on its own
`timescale 1ns/1ps
module cond_move_divide_unit_tb_top
    import cmd_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic insn_valid = 1'b0, cond_flag = 1'b0, overflow_exception_enable = 1'b0, div_zero_exception_enable = 1'b0;
    logic [INSN_W-1:0] insn = '0;
    logic [XLEN-1:0] opnd_a = '0, opnd_b = '0, wb_data;
    logic pipeline_idle, busy, wb_valid, overflow_flag_we, overflow_flag, carry_flag_we, carry_flag;
    logic range_exception, illegal_insn, pipeline_flush, context_reload;
    logic [4:0] wb_dest;
    logic [3:0] hold_cycles = 4'h0;
    int n_mismatch = 0, checked = 0;
    always #12.5 mclk = ~mclk;
    cmd_exec DUT (.*);
    cmd_pipe_model u_pipe (.mclk(mclk), .resetn(resetn), .busy(busy), .hold_cycles(hold_cycles), .pipeline_idle(pipeline_idle));
    task automatic cmp(input logic [XLEN-1:0] got, input logic [XLEN-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Returns just after the take edge, outputs settled
    task automatic issue(input logic [INSN_W-1:0] w, input logic [XLEN-1:0] a, input logic [XLEN-1:0] b, input logic f);
        @(posedge mclk);
        insn_valid <= 1'b1;
        insn <= w;
        opnd_a <= a;
        opnd_b <= b;
        cond_flag <= f;
        @(posedge mclk);
        insn_valid <= 1'b0;
        #1;
    endtask
    function automatic logic [INSN_W-1:0] enc(input logic [1:0] sub, input logic [3:0] fn);
        return {OPC_ALU, 5'h0b, 10'h0, 1'b0, sub, 4'h0, fn};
    endfunction
    task automatic t_cmov();
        for (int f = 0; f < 2; f++)
        begin
            issue(enc(SUB_CMOV, FN_CMOV), 32'ha5a5a5a5, 32'h5a5a5a5a, f[0]);
            cmp(wb_valid, 1);
            cmp(wb_data, f ? 32'ha5a5a5a5 : 32'h5a5a5a5a);
            cmp(wb_dest, 32'hb);
        end
    endtask
    task automatic t_div();
        logic [XLEN-1:0] a [4] = '{32'hfffffff9, 32'h64, 32'hffffffff, 32'h7};
        logic [XLEN-1:0] b [4] = '{32'h2, 32'hfffffff9, 32'h10000, 32'h2};
        logic [XLEN-1:0] q;
        int n;
        for (int i = 0; i < 4; i++)
        begin
            issue(enc(SUB_DIV, i < 2 ? FN_DIV : FN_DIVU), a[i], b[i], 1'b0);
            cmp(i < 2 ? {overflow_flag_we, overflow_flag} : {carry_flag_we, carry_flag}, 2);
            if (i < 2)
                q = $signed(a[i]) / $signed(b[i]);
            else
                q = a[i] / b[i];
            n = 0;
            while (!wb_valid && n < 40)
            begin
                @(posedge mclk);
                #1;
                n++;
            end
            cmp(n, 33);
            cmp(wb_data, q);
            cmp(wb_dest, 32'hb);
        end
    endtask
    task automatic t_zero();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk);
            overflow_exception_enable <= i[0];
            div_zero_exception_enable <= i[1];
            issue(enc(SUB_DIV, i[2] ? FN_DIVU : FN_DIV), 32'h1234, 32'h0, 1'b0);
            cmp(i[2] ? carry_flag : overflow_flag, 1);
            cmp(range_exception, i[0] & i[1]);
            cmp(busy | wb_valid, 0);
        end
    endtask
    task automatic t_sync();
        int n;
        for (int h = 0; h < 7; h += 6)
        begin
            @(posedge mclk);
            hold_cycles <= h[3:0];
            issue(INSN_CSYNC, 32'h0, 32'h0, 1'b0);
            n = 1;
            while (!pipeline_flush && n < 60)
            begin
                @(posedge mclk);
                #1;
                n++;
            end
            cmp(h > 0 ? n > 4 : n == 4, 1);
            cmp(context_reload & !busy, 1);
        end
    endtask
    task automatic t_cust();
        for (int i = 0; i < 8; i++)
        begin
            issue({i[2], 3'h7, i[1:0], 26'h2a5}, 32'h1, 32'h2, 1'b1);
            cmp(illegal_insn, 1);
            cmp(wb_valid | range_exception, 0);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        t_cmov();
        t_div();
        t_zero();
        t_sync();
        t_cust();
        tally_and_finish();
    end
    initial
    begin
        #100us;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
